// >>> verilog/telegram_pkg.sv
`default_nettype none
package telegram_pkg;
  // Serial link defaults: 8N1
  localparam int CLK_HZ = 125000000;
  localparam int BAUD_DEFAULT = 38400;
  localparam int DATA_BITS = 8;
  // Telegram layout
  localparam int REQ_LEN = 3;
  localparam int RSP_LEN = 9;
  localparam logic [7:0] REQ_HDR_MASK = 8'hc0;
  localparam logic [7:0] CMD_POS_SPD_ONCE = 8'hf8;
  localparam logic [7:0] CMD_POS_SPD_CYCLIC = 8'hf9;
  localparam logic [7:0] CMD_STOP_CYCLIC = 8'hf3;
  // Cyclic interval, milliseconds
  localparam int CYCLE_MS_MAX = 30;
  localparam int CYCLE_MS_DEFAULT = 30;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  // Factory defaults of measurement
  localparam int INTEG_DEPTH_DEFAULT = 8;
  localparam int RESOLUTION_MM_DEFAULT = 1;
  localparam logic GRID_40MM = 1'b1;
  localparam logic GRID_30MM = 1'b0;
  // Quality thresholds, percent
  localparam logic [6:0] QUAL_HI = 7'h4b;
  localparam logic [6:0] QUAL_MID = 7'h32;
  localparam logic [6:0] QUAL_LO = 7'h19;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CYCLE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CONFIG = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
endpackage : telegram_pkg
`default_nettype wire

// >>> verilog/position_speed_telegram.sv
// Functional notes
// - Commands F8/F9 with good check byte trigger a nine-byte answer.
// - Requests with wrong check byte are discarded without any answer.
// - Cyclic mode repeats answer at software-set interval up to 30 ms.
// - Same byte content on RS-232 and RS-422.
// - Bytes two to five carry 32-bit position, bit zero LSB.
// - Bytes six and seven carry 16-bit speed, bit zero LSB.
// - Orientation flag 1 when turned half a turn; ready flag 1 ready.
// - Switching-line flags report 1 when their level is active.
// - Temperature flag set when temperature is out of range.
// - Quality field 00/01/10/11 by 75, 50, 25 percent bands.
// - Sleep flag shows standby or sleep mode active.
// - Marker-pending flag set while marker data awaits retrieval.
// - Fault-report flag set while diagnostic data awaits retrieval.
// - Value-invalid and device-fault flags reported separately.
// - Check byte bit is even parity of its column over prior bytes.
// - Default link is 38400 baud, 8 data bits, no parity, one stop.
// - Default integration depth is eight measurements.
// - Default position resolution is 1 mm per LSB.
// - Grid select chooses 40 mm or 30 mm, default 40 mm.
// - Line A default: active-high level output, set on invalid position.
// - Line B default: active-high edge input, rising edge loads preset.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module position_speed_telegram
  import telegram_pkg::*;
#(
  parameter int BAUD = BAUD_DEFAULT,
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input wire logic i_clk_sys, // System clock 125 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_rxd, // Serial receive pin
  output logic o_txd, // Serial transmit pin
  input wire logic [31:0] i_position, // Measured position
  input wire logic [15:0] i_speed, // Measured speed
  input wire logic i_turned, // Sensor turned half a turn
  input wire logic i_ready, // Device ready
  input wire logic i_temp_out_of_range, // Temperature out of range
  input wire logic [6:0] i_quality_pct, // Reading quality percent
  input wire logic i_sleep, // Standby or sleep active
  input wire logic i_marker_held, // Marker data in memory
  input wire logic i_fault_report_held, // Diagnostic data in memory
  input wire logic i_value_invalid, // Measurement value invalid
  input wire logic i_device_fault, // Device error
  input wire logic i_switching_line_b, // Line B input pin
  output logic o_switching_line_a, // Line A output pin
  output logic o_preset_load, // Pulse: read in preset value
  output logic o_grid_40mm, // Grid select, 1 = 40 mm
  output logic [3:0] o_integ_depth, // Position integration depth
  output logic [3:0] o_resolution_mm, // Position resolution setting
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);

  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_CYCLES = BIT_CYCLES / 2;
  localparam logic [15:0] BIT_CNT = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_CNT = 16'(HALF_CYCLES - 1);
  localparam logic [16:0] MS_CNT = 17'(MS_CYCLES - 1);
  localparam logic [4:0] CYCLE_DEF = 5'(CYCLE_MS_DEFAULT);
  localparam logic [4:0] CYCLE_MAX = 5'(CYCLE_MS_MAX);
  localparam logic [3:0] DEPTH_DEF = 4'(INTEG_DEPTH_DEFAULT);
  localparam logic [3:0] RES_DEF = 4'(RESOLUTION_MM_DEFAULT);
  localparam logic [3:0] RSP_LAST = 4'(RSP_LEN - 1);
  localparam logic [1:0] REQ_LAST = 2'(REQ_LEN - 1);

  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535 || MS_CYCLES < 1
      || MS_CYCLES > 131071) begin : g_bad_params
    $error("unsupported BAUD or MS_CYCLES");
  end

  typedef struct packed {
    logic [1:0] rxs; // Pin synchronisers
    logic [1:0] lbs;
    logic lb_last;
    // Receiver
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [1:0] req_idx;
    logic [7:0] req0;
    logic [7:0] req1;
    // Transmit
    tx_state_e tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [3:0] tx_idx;
    logic [7:0] tx_sh;
    logic [71:0] frame;
    logic txd;
    logic send_req;
    // Cyclic
    logic cyclic;
    logic [16:0] ms_cnt;
    logic [4:0] ms_left;
    // Config and status
    logic [4:0] cycle_ms;
    logic grid40;
    logic [3:0] depth;
    logic [3:0] res_mm;
    logic [7:0] bad_cnt;
    logic [7:0] tx_cnt_frames;
    logic line_a;
    logic preset;
    // Bus
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s s_reg, s_next;

  // Column parity of all bytes preceding the check byte
  function automatic logic [7:0] col_parity(input logic [63:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p = p ^ b[i*8 +: 8];
    end
    return p;
  endfunction : col_parity

  // Quality percent to two-bit band
  function automatic logic [1:0] qual_band(input logic [6:0] q);
    if (q >= QUAL_HI) return 2'b00;
    else if (q >= QUAL_MID) return 2'b01;
    else if (q >= QUAL_LO) return 2'b10;
    else return 2'b11;
  endfunction : qual_band

  logic [7:0] stat0, stat1;
  logic [63:0] body;
  logic [7:0] chk_req;

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    stat0 = {i_turned, i_ready, s_reg.lbs[1], s_reg.line_a, 4'h0};
    stat1 = {i_temp_out_of_range,
             qual_band(i_quality_pct), i_sleep,
             i_marker_held, i_fault_report_held,
             i_value_invalid, i_device_fault};
    body = {stat0, stat1, i_position, i_speed};
    chk_req = s_reg.req0 ^ s_reg.req1;
    s_next.preset = 1'b0;
    if (s_reg.tx_st == TX_IDLE && s_reg.send_req) s_next.send_req = 1'b0;

    // Synchronisers and switching lines
    s_next.rxs = {s_reg.rxs[0], i_rxd};
    s_next.lbs = {s_reg.lbs[0], i_switching_line_b};
    s_next.lb_last = s_reg.lbs[1];
    if (s_reg.lbs[1] && !s_reg.lb_last) begin
      s_next.preset = 1'b1;
    end
    s_next.line_a = i_value_invalid;

    // UART receiver, 8N1
    if (!s_reg.rx_busy) begin
      if (!s_reg.rxs[1]) begin
        s_next.rx_busy = 1'b1;
        s_next.rx_cnt = HALF_CNT;
        s_next.rx_bit = 4'h0;
      end
    end else if (s_reg.rx_cnt != 16'h0000) begin
      s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
    end else begin
      s_next.rx_cnt = BIT_CNT;
      s_next.rx_bit = s_reg.rx_bit + 4'h1;
      if (s_reg.rx_bit == 4'h0) begin
        if (s_reg.rxs[1]) s_next.rx_busy = 1'b0; // False start
      end else if (s_reg.rx_bit <= 4'(DATA_BITS)) begin
        s_next.rx_sh = {s_reg.rxs[1], s_reg.rx_sh[7:1]};
      end else begin
        s_next.rx_busy = 1'b0;
        if (s_reg.rxs[1]) begin
          // Request assembly
          if (s_reg.req_idx == 2'd0) begin
            if ((s_reg.rx_sh & REQ_HDR_MASK) == REQ_HDR_MASK) begin
              s_next.req0 = s_reg.rx_sh;
              s_next.req_idx = 2'd1;
            end
          end else if (s_reg.req_idx == 2'd1) begin
            s_next.req1 = s_reg.rx_sh;
            s_next.req_idx = REQ_LAST;
          end else begin
            s_next.req_idx = 2'd0;
            if (s_reg.rx_sh != chk_req) begin
              s_next.bad_cnt = s_reg.bad_cnt + 8'h01;
            end else if (s_reg.req1 == CMD_POS_SPD_ONCE) begin
              s_next.send_req = 1'b1;
              s_next.cyclic = 1'b0;
            end else if (s_reg.req1 == CMD_POS_SPD_CYCLIC) begin
              s_next.send_req = 1'b1;
              s_next.cyclic = 1'b1;
              s_next.ms_cnt = MS_CNT;
              s_next.ms_left = s_reg.cycle_ms;
            end else if (s_reg.req1 == CMD_STOP_CYCLIC) begin
              s_next.cyclic = 1'b0;
            end
          end
        end else begin
          s_next.req_idx = 2'd0; // Framing error drops request
        end
      end
    end

    // Cyclic interval timer
    if (s_reg.cyclic) begin
      if (s_reg.ms_cnt != 17'h00000) begin
        s_next.ms_cnt = s_reg.ms_cnt - 17'h00001;
      end else begin
        s_next.ms_cnt = MS_CNT;
        if (s_reg.ms_left <= 5'h01) begin
          s_next.ms_left = s_reg.cycle_ms;
          s_next.send_req = 1'b1;
        end else begin
          s_next.ms_left = s_reg.ms_left - 5'h01;
        end
      end
    end

    // Transmitter, one frame per request; latched body is stable
    case (s_reg.tx_st)
      TX_IDLE: begin
        s_next.txd = 1'b1;
        if (s_reg.send_req) begin
          s_next.frame = {body, col_parity(body)};
          s_next.tx_idx = 4'h0;
          s_next.tx_st = TX_START;
          s_next.tx_cnt = BIT_CNT;
          s_next.tx_sh = body[63:56];
          s_next.txd = 1'b0;
        end
      end
      TX_START: begin
        if (s_reg.tx_cnt != 16'h0000) begin
          s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
        end else begin
          s_next.tx_cnt = BIT_CNT;
          s_next.tx_bit = 3'h0;
          s_next.txd = s_reg.tx_sh[0];
          s_next.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (s_reg.tx_cnt != 16'h0000) begin
          s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
        end else begin
          s_next.tx_cnt = BIT_CNT;
          s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
          s_next.tx_bit = s_reg.tx_bit + 3'h1;
          if (s_reg.tx_bit == 3'(DATA_BITS - 1)) begin
            s_next.txd = 1'b1;
            s_next.tx_st = TX_STOP;
          end else begin
            s_next.txd = s_reg.tx_sh[1];
          end
        end
      end
      TX_STOP: begin
        if (s_reg.tx_cnt != 16'h0000) begin
          s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
        end else if (s_reg.tx_idx == RSP_LAST) begin
          s_next.tx_st = TX_IDLE;
          s_next.tx_cnt_frames = s_reg.tx_cnt_frames + 8'h01;
        end else begin
          s_next.tx_idx = s_reg.tx_idx + 4'h1;
          s_next.tx_sh = s_reg.frame[8*(7 - s_reg.tx_idx) +: 8];
          s_next.tx_cnt = BIT_CNT;
          s_next.txd = 1'b0;
          s_next.tx_st = TX_START;
        end
      end
      default: s_next.tx_st = TX_IDLE;
    endcase

    // AXI4-Lite write channel
    if (s_axi_awvalid && !s_reg.aw_got) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      case ({s_reg.aw_addr[7:2], 2'b00})
        REG_CTRL: begin
          if (s_reg.w_strb[0]) begin
            if (s_reg.w_data[0]) s_next.send_req = 1'b1;
            if (s_reg.w_data[1]) s_next.cyclic = 1'b0;
          end
        end
        REG_CYCLE: begin
          if (s_reg.w_strb[0]) begin
            if (s_reg.w_data[4:0] == 5'h00) s_next.cycle_ms = 5'h01;
            else if (s_reg.w_data[4:0] > CYCLE_MAX) s_next.cycle_ms = CYCLE_MAX;
            else s_next.cycle_ms = s_reg.w_data[4:0];
          end
        end
        REG_CONFIG: begin
          if (s_reg.w_strb[0]) begin
            s_next.grid40 = s_reg.w_data[0];
            s_next.depth = s_reg.w_data[7:4];
          end
          if (s_reg.w_strb[1]) s_next.res_mm = s_reg.w_data[11:8];
        end
        REG_STATUS: ;
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;

    // AXI4-Lite read channel
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL: s_next.rdata = {30'h0, 1'b0, s_reg.cyclic};
        REG_CYCLE: s_next.rdata = {27'h0, s_reg.cycle_ms};
        REG_STATUS: s_next.rdata = {8'h00, s_reg.bad_cnt,
                                    s_reg.tx_cnt_frames, stat0[7:4],
                                    2'b00, s_reg.tx_st != TX_IDLE,
                                    s_reg.cyclic};
        REG_CONFIG: s_next.rdata = {20'h0, s_reg.res_mm, s_reg.depth,
                                    3'h0, s_reg.grid40};
        default: begin
          s_next.rdata = 32'h0;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
      s_reg.rxs <= 2'b11;
      s_reg.txd <= 1'b1;
      s_reg.tx_st <= TX_IDLE;
      s_reg.cycle_ms <= CYCLE_DEF;
      s_reg.grid40 <= GRID_40MM;
      s_reg.depth <= DEPTH_DEF;
      s_reg.res_mm <= RES_DEF;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops; framing identical on RS-232 and RS-422
  assign o_txd = s_reg.txd;
  assign o_switching_line_a = s_reg.line_a;
  assign o_preset_load = s_reg.preset;
  assign o_grid_40mm = s_reg.grid40;
  assign o_integ_depth = s_reg.depth;
  assign o_resolution_mm = s_reg.res_mm;
  assign s_axi_awready = !s_reg.aw_got;
  assign s_axi_wready = !s_reg.w_got;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

endmodule : position_speed_telegram
`default_nettype wire

// >>> bench/telegram_props.sv
`timescale 1ns/1ps
`default_nettype none
module telegram_props
  import telegram_pkg::*;
#(
  parameter int BAUD = BAUD_DEFAULT
) (
  input wire logic i_clk_sys, // Clock
  input wire logic i_resetn, // Reset
  input wire logic i_value_invalid, // Invalid
  input wire logic i_switching_line_b, // Line B
  input wire logic o_switching_line_a, // Line A
  input wire logic o_preset_load, // Preset
  input wire logic o_txd, // Serial out
  input wire logic o_grid_40mm, // Grid
  input wire logic [3:0] o_integ_depth, // Depth
  input wire logic [3:0] o_resolution_mm, // Res
  input wire logic s_axi_awvalid, // AW
  input wire logic s_axi_awready, // AW
  input wire logic s_axi_wvalid, // W
  input wire logic s_axi_wready, // W
  input wire logic s_axi_bvalid, // B
  input wire logic s_axi_arvalid, // AR
  input wire logic s_axi_arready, // AR
  input wire logic s_axi_rvalid, // R
  input wire logic s_axi_rready // R ready
);
  localparam int BIT = CLK_HZ / BAUD;
  int unsigned run_reg;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Cycles spent at the current serial level
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      run_reg <= 0;
    end else begin
      run_reg <= $changed(o_txd) ? 1 : run_reg + 1;
    end
  end
  a_txd_bit_time: assert property ($rose(o_txd) |->
    run_reg % BIT == 0 && run_reg <= 9 * BIT)
    else $error("serial low stretch not whole bits");
  a_line_a_level: assert property ($changed(i_value_invalid) |=>
    o_switching_line_a == $past(i_value_invalid))
    else $error("line a does not follow invalid");
  a_preset_rise: assert property ($rose(i_switching_line_b) |->
    ##[1:8] o_preset_load) else $error("no preset pulse");
  a_preset_once: assert property (o_preset_load |=> !o_preset_load)
    else $error("preset pulse too long");
  a_config_defaults: assert property ($rose(i_resetn) |->
    o_grid_40mm && o_integ_depth == 4'h8 && o_resolution_mm == 4'h1)
    else $error("config defaults wrong");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_rd_retire: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read answer not retired");
  c_preset: cover property (o_preset_load);
  c_frame: cover property ($rose(o_txd));
  c_write: cover property (s_axi_bvalid);
endmodule : telegram_props
bind position_speed_telegram telegram_props #(.BAUD(BAUD)) telegram_props_i (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_value_invalid(i_value_invalid),
  .i_switching_line_b(i_switching_line_b),
  .o_switching_line_a(o_switching_line_a), .o_preset_load(o_preset_load),
  .o_txd(o_txd), .o_grid_40mm(o_grid_40mm), .o_integ_depth(o_integ_depth),
  .o_resolution_mm(o_resolution_mm), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> bench/link_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_controller_model #(
  parameter int BIT = 10
) (
  input wire logic i_clk_sys, // Clock
  output logic o_rxd, // Requests out
  input wire logic i_txd // Responses in
);
  logic [7:0] rx_q[$];
  int t_q[$];
  int cyc = 0;
  int bad_stop = 0;
  logic [8:0] sh;
  initial o_rxd = 1'b1;
  // Free running cycle count
  always @(posedge i_clk_sys) cyc++;
  // Three byte request, gap in idle bit times between bytes
  task automatic send(input logic [7:0] cmd, input logic bad, input int gap);
    logic [7:0] b[3];
    b = '{8'hc0, cmd, 8'hc0 ^ cmd ^ {7'h0, bad}};
    foreach (b[i]) begin
      for (int k = 0; k < 10; k++) begin
        o_rxd <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : b[i][k - 1];
        repeat (BIT) @(posedge i_clk_sys);
      end
      repeat (gap * BIT) @(posedge i_clk_sys);
    end
  endtask : send
  // Sample response bytes mid bit, lsb first
  initial forever begin
    @(negedge i_txd);
    t_q.push_back(cyc);
    repeat (BIT / 2) @(posedge i_clk_sys);
    for (int k = 0; k < 9; k++) begin
      repeat (BIT) @(posedge i_clk_sys);
      sh = {i_txd, sh[8:1]};
    end
    if (sh[8] !== 1'b1) bad_stop++;
    rx_q.push_back(sh[7:0]);
  end
endmodule : link_controller_model
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
  import telegram_pkg::*;
  localparam int BAUD = 12500000;
  logic clk, rst_n, rxd, txd, line_a, preset, grid;
  logic [31:0] pos, wdata, rdata;
  logic [15:0] spd;
  logic [8:0] fl;
  logic [6:0] qual;
  logic [3:0] depth, res;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  position_speed_telegram #(.BAUD(BAUD), .MS_CYCLES(100))
    position_speed_telegram_i (
    .i_clk_sys(clk), .i_resetn(rst_n), .i_rxd(rxd), .o_txd(txd),
    .i_position(pos), .i_speed(spd), .i_turned(fl[8]), .i_ready(fl[7]),
    .i_temp_out_of_range(fl[6]), .i_quality_pct(qual), .i_sleep(fl[5]),
    .i_marker_held(fl[4]), .i_fault_report_held(fl[3]),
    .i_value_invalid(fl[2]),
    .i_device_fault(fl[1]), .i_switching_line_b(fl[0]),
    .o_switching_line_a(line_a), .o_preset_load(preset), .o_grid_40mm(grid),
    .o_integ_depth(depth), .o_resolution_mm(res),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  link_controller_model #(.BIT(CLK_HZ / BAUD)) model_i (
    .i_clk_sys(clk), .o_rxd(rxd), .i_txd(txd));
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    `CHK({grid, depth, res}, 9'h181)
    rd(REG_CONFIG, d, r);
    `CHK(d[11:0], 12'h181)
    rd(REG_CYCLE, d, r);
    `CHK(d[4:0], 5'd30)
    rd(8'h10, d, r);
    `CHK(r, RESP_SLVERR)
    wr(8'h10, 32'h0, r);
    `CHK(r, RESP_SLVERR)
    wr(REG_CONFIG, 32'h0, r);
    `CHK(grid, GRID_30MM)
    wr(REG_CONFIG, 32'h181, r);
    `CHK(r, RESP_OKAY)
  endtask : t_regs
  task automatic t_lines();
    int n = 0;
    fl <= 9'h004;
    repeat (3) @(posedge clk);
    `CHK(line_a, 1'b1)
    fl <= 9'h001;
    repeat (12) begin
      @(posedge clk);
      n += (preset === 1'b1);
    end
    `CHK(line_a, 1'b0)
    `CHK(n, 1)
  endtask : t_lines
  task automatic t_frames();
    logic [6:0] qt[4] = '{7'd75, 7'd50, 7'd25, 7'd24};
    logic [8:0] ft[4] = '{9'h1aa, 9'h155, 9'h1ff, 9'h000};
    logic [7:0] e[9];
    logic [1:0] q;
    for (int i = 0; i < 4; i++) begin
      qual <= qt[i];
      fl <= ft[i];
      pos <= 32'h80f12c03 + i * 32'h01010101;
      spd <= 16'h8e01 - i;
      repeat (4) @(posedge clk);
      q = qual >= 75 ? 2'b00 : qual >= 50 ? 2'b01 : qual >= 25 ? 2'b10 : 2'b11;
      e = '{{fl[8], fl[7], fl[0], fl[2], 4'h0}, {fl[6], q, fl[5:1]},
        pos[31:24], pos[23:16], pos[15:8], pos[7:0], spd[15:8], spd[7:0],
        8'h00};
      for (int k = 0; k < 8; k++) e[8] ^= e[k];
      model_i.rx_q.delete();
      model_i.send(CMD_POS_SPD_ONCE, 1'b0, 0);
      while (model_i.rx_q.size() < 9) @(posedge clk);
      for (int k = 0; k < 9; k++) `CHK(model_i.rx_q[k], e[k])
    end
    `CHK(model_i.bad_stop, 0)
  endtask : t_frames
  task automatic t_bad();
    logic [31:0] s0, s1;
    logic [1:0] r;
    rd(REG_STATUS, s0, r);
    model_i.rx_q.delete();
    model_i.send(CMD_POS_SPD_ONCE, 1'b1, 3);
    repeat (1200) @(posedge clk);
    `CHK(model_i.rx_q.size(), 0)
    rd(REG_STATUS, s1, r);
    `CHK(s1[23:16], s0[23:16] + 8'h01)
    model_i.rx_q.delete();
    wr(REG_CTRL, 32'h1, r);
    while (model_i.rx_q.size() < 9) @(posedge clk);
    s0 = '0;
    for (int k = 0; k < 9; k++) s0[7:0] ^= model_i.rx_q[k];
    `CHK(s0[7:0], 8'h00)
  endtask : t_bad
  task automatic t_cyclic();
    logic [31:0] d;
    logic [1:0] r;
    int dt;
    wr(REG_CYCLE, 32'h0, r);
    rd(REG_CYCLE, d, r);
    `CHK(d[4:0], 5'd1)
    wr(REG_CYCLE, 32'h1f, r);
    rd(REG_CYCLE, d, r);
    `CHK(d[4:0], 5'd30)
    wr(REG_CYCLE, 32'hf, r);
    model_i.rx_q.delete();
    model_i.t_q.delete();
    model_i.send(CMD_POS_SPD_CYCLIC, 1'b0, 0);
    while (model_i.rx_q.size() < 27) @(posedge clk);
    dt = model_i.t_q[18] - model_i.t_q[0];
    `CHK(dt >= 2980 && dt <= 3020, 1'b1)
    rd(REG_CTRL, d, r);
    `CHK(d[0], 1'b1)
    model_i.send(CMD_STOP_CYCLIC, 1'b0, 0);
    repeat (1000) @(posedge clk);
    model_i.rx_q.delete();
    repeat (2000) @(posedge clk);
    `CHK(model_i.rx_q.size(), 0)
    model_i.send(CMD_POS_SPD_CYCLIC, 1'b0, 0);
    wr(REG_CTRL, 32'h2, r);
    rd(REG_CTRL, d, r);
    `CHK(d[0], 1'b0)
  endtask : t_cyclic
  // Reset, then scenarios
  initial begin
    rst_n = 1'b0;
    {fl, qual, pos, spd, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_lines();
    t_frames();
    t_bad();
    t_cyclic();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
